// file: hdl/cpr_pkg.sv
package cpr_pkg;
    // Command encodings on {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CPR_CMD_MRS = 4'h0;
    localparam logic [3:0] CPR_CMD_REF = 4'h1;
    localparam logic [3:0] CPR_CMD_PRE = 4'h2;
    localparam logic [3:0] CPR_CMD_ACT = 4'h3;
    localparam logic [3:0] CPR_CMD_WR = 4'h4;
    localparam logic [3:0] CPR_CMD_RD = 4'h5;
    localparam logic [3:0] CPR_CMD_NOP = 4'h7;
    // Bank address selecting each mode register
    localparam logic [2:0] CPR_BA_REFRESH_MR = 3'h2;
    localparam logic [2:0] CPR_BA_PATTERN_MR = 3'h3;
    // Field positions in the address word
    localparam int CPR_PAT_EN_BIT = 2;
    localparam int CPR_PAT_LOC_LSB = 0;
    localparam int CPR_SRT_BIT = 7;
    localparam int CPR_AP_BIT = 10;
    // Widths and burst shape
    localparam int CPR_ADDR_W = 14;
    localparam int CPR_DQ_W = 16;
    localparam int CPR_BURST_LEN = 8;
    // Read latency in clocks, burst shape
    localparam logic [4:0] CPR_READ_LAT = 5'h0B;
    localparam logic [3:0] CPR_BURST_BEATS = 4'h8;
    // Predefined calibration sequence, one bit per beat, beat 0 in bit 0
    localparam logic [7:0] CPR_PATTERN = 8'hAA;
    // Reset values
    localparam logic CPR_PAT_EN_RST = 1'b0;
    localparam logic [1:0] CPR_PAT_LOC_RST = 2'h0;
    localparam logic CPR_SRT_RST = 1'b0;
    // Refresh intervals
    localparam real CPR_AVERAGE_REFRESH_INTERVAL_NORM_US = 7.8;
    localparam real CPR_AVERAGE_REFRESH_INTERVAL_EXT_US = 3.9;
    localparam real CPR_CLK_MHZ = 250.0;
    localparam int CPR_AVERAGE_REFRESH_INTERVAL_NORM_CYC = int'($floor(CPR_AVERAGE_REFRESH_INTERVAL_NORM_US *
                                                    CPR_CLK_MHZ));
    localparam int CPR_AVERAGE_REFRESH_INTERVAL_EXT_CYC = int'($floor(CPR_AVERAGE_REFRESH_INTERVAL_EXT_US *
                                                   CPR_CLK_MHZ));

    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [2:0] ba;
        logic [CPR_ADDR_W-1:0] addr;
    } cpr_cmd_t;

    typedef struct packed {
        logic [CPR_DQ_W-1:0] dq;
        logic dq_oe;
        logic dqs;
        logic dqs_oe;
    } cpr_data_t;

    typedef enum logic [1:0] {
        CPR_IDLE,
        CPR_WAIT,
        CPR_BURST
    } cpr_state_t;
endpackage : cpr_pkg

// file: hdl/cpr_readout.sv
// Overview of operation
// RQ1: A mode register write to the pattern register with A2 high enables pattern readout.
// RQ2: The controller must have all banks idle and precharged before that enabling write.
// RQ3: While enabled, every read and read with autoprecharge is served from the pattern; the code ignores reads during a pending burst.
// RQ4: While enabled, the controller issues only reads until a write clears A2.
// RQ5: The controller enters no power-down or self-refresh while pattern readout is on.
// RQ6: Reset is honoured while pattern readout is enabled and returns all state to idle.
// RQ7: At extended temperature the controller halves its average refresh interval.
// RQ8: Extended temperature self-refresh is set through bit A7 of the refresh register.
// RQ9: With A2 low the pattern location field in A1 and A0 is ignored.
// RQ10: The pattern register is written with all strobes low and bank address 3.
// RQ11: With the temperature bit set, internal self-refresh runs at twice the rate.
// RQ12: A redirected read returns the pattern as a normal burst at read latency; the code drives the first beat CPR_READ_LAT plus 3 clocks after the read.
`timescale 1ns/100ps
module cpr_readout
    import cpr_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Command bus from the controller
    input wire cpr_cmd_t cmd_in,
    // Data pins
    output cpr_data_t data_out,
    // Mode state
    output logic pattern_mode,
    output logic [1:0] pattern_loc,
    output logic srt_enable,
    output logic self_refresh_2x,
    output logic array_read,
    output logic illegal_cmd
);
    cpr_cmd_t cmd_s1;
    cpr_cmd_t cmd;
    cpr_state_t state;
    cpr_state_t next_state;
    logic [4:0] lat_cnt;
    logic [3:0] beat;
    logic [4:0] next_lat_cnt;
    logic [3:0] next_beat;

    wire [3:0] cmd_code = {cmd.cs_n, cmd.ras_n, cmd.cas_n, cmd.we_n};
    wire is_read = (cmd_code == CPR_CMD_RD);
    wire is_mrs = (cmd_code == CPR_CMD_MRS);
    // RQ10 pattern register decode
    wire mrs_pattern = is_mrs && (cmd.ba == CPR_BA_PATTERN_MR);
    wire mrs_refresh = is_mrs && (cmd.ba == CPR_BA_REFRESH_MR);
    wire new_pat_en = cmd.addr[CPR_PAT_EN_BIT];
    wire legal_in_mode = is_read || mrs_pattern || cmd.cs_n ||
                         (cmd_code == CPR_CMD_NOP);
    // RQ3 reads take the pattern
    wire pat_read = is_read && pattern_mode;
    wire start_burst = pat_read && (state == CPR_IDLE);
    wire [3:0] beat_idx = beat - 4'h1;
    wire pat_bit = CPR_PATTERN[beat_idx[2:0]];

    // Pins are outside the clock domain
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            cmd_s1 <= '1;
            cmd <= '1;
        end
        else
        begin
            cmd_s1 <= cmd_in;
            cmd <= cmd_s1;
        end
    end

    // RQ1 RQ9 RQ6 pattern enable and location
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            pattern_mode <= CPR_PAT_EN_RST;
            pattern_loc <= CPR_PAT_LOC_RST;
        end
        else if (mrs_pattern)
        begin
            pattern_mode <= new_pat_en;
            // Location is held only while the pattern is selected
            pattern_loc <= new_pat_en ?
                cmd.addr[CPR_PAT_LOC_LSB +: 2] : CPR_PAT_LOC_RST;
        end
    end

    // RQ8 RQ11 self-refresh temperature bit
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            srt_enable <= CPR_SRT_RST;
            self_refresh_2x <= CPR_SRT_RST;
        end
        else if (mrs_refresh)
        begin
            srt_enable <= cmd.addr[CPR_SRT_BIT];
            self_refresh_2x <= cmd.addr[CPR_SRT_BIT];
        end
    end

    // Flags reads that go to the array and commands barred in pattern mode
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            array_read <= 1'b0;
            illegal_cmd <= 1'b0;
        end
        else
        begin
            array_read <= is_read && !pattern_mode;
            illegal_cmd <= pattern_mode && !legal_in_mode;
        end
    end

    // RQ12 burst sequencer at read latency
    always_comb
    begin
        next_state = state;
        next_lat_cnt = lat_cnt;
        next_beat = beat;
        case (state)
            CPR_IDLE:
            begin
                if (start_burst)
                begin
                    next_state = CPR_WAIT;
                    next_lat_cnt = CPR_READ_LAT;
                end
            end
            CPR_WAIT:
            begin
                next_lat_cnt = lat_cnt - 5'h01;
                if (lat_cnt == 5'h01)
                begin
                    next_state = CPR_BURST;
                    next_beat = CPR_BURST_BEATS;
                end
            end
            CPR_BURST:
            begin
                next_beat = beat - 4'h1;
                if (beat == 4'h1)
                    next_state = CPR_IDLE;
            end
            default:
                next_state = CPR_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= CPR_IDLE;
            lat_cnt <= 5'h00;
            beat <= 4'h0;
        end
        else
        begin
            state <= next_state;
            lat_cnt <= next_lat_cnt;
            beat <= next_beat;
        end
    end

    // Beat numbering counts down, so the pattern is indexed from the end
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            data_out <= '0;
        else if (state == CPR_BURST)
        begin
            data_out.dq <= {CPR_DQ_W{
                CPR_PATTERN[3'(CPR_BURST_LEN) - beat_idx[2:0] - 3'h1]}};
            data_out.dq_oe <= 1'b1;
            data_out.dqs <= pat_bit;
            data_out.dqs_oe <= 1'b1;
        end
        else
            data_out <= '0;
    end
endmodule : cpr_readout

// file: test/cpr_readout_assertions.sv
`timescale 1ns/100ps
module cpr_readout_assertions
    import cpr_pkg::*;
(
    // Watched ports
    input wire logic mclk,
    input wire logic rstn,
    input wire cpr_cmd_t cmd_in,
    input wire cpr_data_t data_out,
    input wire logic pattern_mode,
    input wire logic [1:0] pattern_loc,
    input wire logic srt_enable,
    input wire logic self_refresh_2x,
    input wire logic array_read,
    input wire logic illegal_cmd
);
    wire logic [3:0] op = cmd_in[20:17];
    wire logic rd = op == CPR_CMD_RD;
    wire logic pmr = op == CPR_CMD_MRS && cmd_in.ba == CPR_BA_PATTERN_MR;
    wire logic rmr = op == CPR_CMD_MRS && cmd_in.ba == CPR_BA_REFRESH_MR;
    wire logic oe = data_out.dq_oe;
    logic [2:0] beat;
    always_ff @(posedge mclk or negedge rstn)
        if (!rstn)
            beat <= 3'h0;
        else
            beat <= oe ? beat + 3'h1 : 3'h0;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    property p_mode;
        pmr |-> ##4 pattern_mode == $past(cmd_in.addr[2], 4);
    endproperty
    a_mode: assert property (p_mode) else $error("mode bit wrong");
    property p_loc;
        pmr |-> ##4 pattern_loc ==
            ($past(cmd_in.addr[2], 4) ? $past(cmd_in.addr[1:0], 4) : 2'h0);
    endproperty
    a_loc: assert property (p_loc) else $error("location wrong");
    property p_srt;
        rmr |-> ##4 srt_enable == $past(cmd_in.addr[7], 4)
            && self_refresh_2x == srt_enable;
    endproperty
    a_srt: assert property (p_srt) else $error("srt bit wrong");
    property p_rd;
        (rd && pattern_mode) ##1 pattern_mode[*2] |-> ##13 $rose(oe);
    endproperty
    a_rd: assert property (p_rd) else $error("no burst");
    property p_beat;
        oe |-> data_out.dq == {16{CPR_PATTERN[beat]}};
    endproperty
    a_beat: assert property (p_beat) else $error("beat wrong");
    property p_arr;
        (rd && !pattern_mode) ##1 !pattern_mode[*2] |=> array_read;
    endproperty
    a_arr: assert property (p_arr) else $error("no array read");
    property p_ill;
        (op == CPR_CMD_ACT && pattern_mode) ##1 pattern_mode[*2]
            |=> illegal_cmd;
    endproperty
    a_ill: assert property (p_ill) else $error("not flagged");
    property p_rst;
        $rose(rstn) |-> !pattern_mode && !oe && !srt_enable;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state");
endmodule : cpr_readout_assertions

// file: test/cpr_ctrl_model.sv
`timescale 1ns/100ps
module cpr_ctrl_model
    import cpr_pkg::*;
#(
    parameter int ROW_PRE_CYC = 4
)
(
    // Command side
    input wire logic mclk,
    output cpr_cmd_t cmd
);
    localparam int REFRESH_GAP = CPR_AVERAGE_REFRESH_INTERVAL_EXT_CYC;
    initial cmd = {CPR_CMD_NOP, 3'h0, 14'h0000};
    task automatic issue(input logic [3:0] op, input logic [2:0] ba,
                         input logic [13:0] addr);
        @(negedge mclk);
        cmd = {op, ba, addr};
        @(negedge mclk);
        cmd = {CPR_CMD_NOP, 3'h0, 14'h0000};
    endtask : issue
    // precharge all unless leaving pattern mode
    task automatic set_mr(input logic [2:0] ba, input logic [13:0] addr);
        if (!(ba == CPR_BA_PATTERN_MR && !addr[2]))
        begin
            issue(CPR_CMD_PRE, 3'h0, 14'h0400);
            repeat (ROW_PRE_CYC) @(negedge mclk);
        end
        issue(CPR_CMD_MRS, ba, addr);
    endtask : set_mr
endmodule : cpr_ctrl_model

// file: test/cpr_readout_tb.sv
`timescale 1ns/100ps
module cpr_readout_tb;
    import cpr_pkg::*;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    cpr_cmd_t cmd;
    cpr_data_t data_out;
    logic pattern_mode, srt_enable, self_refresh_2x, array_read, illegal_cmd;
    logic [1:0] pattern_loc;
    int miscompares = 0;
    int tests_run = 0;
    initial forever #2 mclk = ~mclk;
    cpr_readout u_cpr_readout(.mclk(mclk), .rstn(rstn), .cmd_in(cmd),
        .data_out(data_out), .pattern_mode(pattern_mode),
        .pattern_loc(pattern_loc), .srt_enable(srt_enable),
        .self_refresh_2x(self_refresh_2x), .array_read(array_read),
        .illegal_cmd(illegal_cmd));
    cpr_ctrl_model u_cpr_ctrl_model(.mclk(mclk), .cmd(cmd));
    task automatic chk(input string nm, input logic [15:0] s, e);
        tests_run++;
        if (s !== e)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic wt(input int n);
        repeat (n) @(negedge mclk);
    endtask : wt
    task automatic summarize;
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : summarize
    task automatic t_mode(input logic en, input logic [1:0] loc);
        u_cpr_ctrl_model.set_mr(CPR_BA_PATTERN_MR, {11'h000, en, loc});
        wt(3);
        chk("pattern_mode", pattern_mode, en);
        chk("pattern_loc", pattern_loc, en ? loc : 2'h0);
    endtask : t_mode
    task automatic t_srt(input logic s);
        u_cpr_ctrl_model.set_mr(CPR_BA_REFRESH_MR, {6'h00, s, 7'h00});
        wt(3);
        chk("srt_enable", srt_enable, s);
        chk("self_refresh_2x", self_refresh_2x, s);
    endtask : t_srt
    // Both read forms; a column address that must not matter
    task automatic t_read(input logic ap, input logic pm);
        u_cpr_ctrl_model.issue(CPR_CMD_RD, 3'h5, {3'h0, ap, 10'h155});
        wt(2);
        chk("array_read", array_read, !pm);
        wt(11);
        for (int k = 0; k < 9; k++)
        begin
            wt(1);
            chk("dq_oe", data_out.dq_oe, pm && k < 8);
            chk("dqs_oe", data_out.dqs_oe, pm && k < 8);
            if (pm && k < 8)
                chk("dq", data_out.dq, {16{CPR_PATTERN[k]}});
        end
    endtask : t_read
    task automatic t_illegal;
        u_cpr_ctrl_model.issue(CPR_CMD_ACT, 3'h0, 14'h0000);
        wt(2);
        chk("illegal_cmd", illegal_cmd, 1'b1);
        chk("pattern_mode", pattern_mode, 1'b1);
    endtask : t_illegal
    task automatic t_reset;
        rstn = 1'b0;
        wt(2);
        rstn = 1'b1;
        wt(1);
        chk("pattern_mode", pattern_mode, 1'b0);
    endtask : t_reset
    initial
    begin
        wt(16);
        rstn = 1'b1;
        t_srt(1'b1);
        t_srt(1'b0);
        t_read(1'b0, 1'b0);
        t_mode(1'b1, 2'h2);
        t_read(1'b0, 1'b1);
        t_read(1'b1, 1'b1);
        t_illegal;
        t_mode(1'b0, 2'h3);
        t_read(1'b1, 1'b0);
        t_mode(1'b1, 2'h1);
        t_reset;
        summarize;
    end
    initial
    begin
        repeat (3000) @(posedge mclk);
        miscompares++;
        summarize;
    end
endmodule : cpr_readout_tb
bind cpr_readout cpr_readout_assertions u_cpr_readout_assertions(
    .mclk(mclk), .rstn(rstn), .cmd_in(cmd_in), .data_out(data_out),
    .pattern_mode(pattern_mode), .pattern_loc(pattern_loc),
    .srt_enable(srt_enable), .self_refresh_2x(self_refresh_2x),
    .array_read(array_read), .illegal_cmd(illegal_cmd));
